/* hw/pif_defs.vh */
// Constants for the peripheral interrupt flag and enable banks.
// Assumes a classic Wishbone slave, 32-bit data, 8-bit registers.
`ifndef PIF_DEFS_VH
`define PIF_DEFS_VH
`define PIF_ADR_CTRL 6'h00
`define PIF_ADR_EN0 6'h04
`define PIF_ADR_EN1 6'h08
`define PIF_ADR_EN2 6'h0C
`define PIF_ADR_EN3 6'h10
`define PIF_ADR_EN4 6'h14
`define PIF_ADR_EN5 6'h18
`define PIF_ADR_EN6 6'h1C
`define PIF_ADR_EN7 6'h20
`define PIF_ADR_FL0 6'h24
`define PIF_ADR_FL1 6'h28
`define PIF_ADR_FL2 6'h2C
`define PIF_ADR_FL3 6'h30
`define PIF_CTRL_GIE_BIT 7
`define PIF_CTRL_PERIPHERAL_IRQ_MASTER_ENABLE_BIT 6
`define PIF_CTRL_EDGE_BIT 0
`define PIF_CTRL_MASK 8'hC1
`define PIF_CTRL_RST 8'h01
`define PIF_EN0_MASK 8'h31
`define PIF_EN1_MASK 8'hC1
`define PIF_EN2_MASK 8'h43
`define PIF_EN3_MASK 8'hF3
`define PIF_EN4_MASK 8'h03
`define PIF_EN5_MASK 8'hF1
`define PIF_EN6_MASK 8'h03
`define PIF_EN7_MASK 8'h31
`define PIF_FL0_MASK 8'h21
`define PIF_FL0_PINCHG_BIT 4
`define PIF_FL1_MASK 8'hC1
`define PIF_FL2_MASK 8'h43
`define PIF_FL3_MASK 8'h03
`define PIF_FL3_RXB_BIT 7
`define PIF_FL3_TXB_BIT 6
`define PIF_FL3_RXA_BIT 5
`define PIF_FL3_TXA_BIT 4
`define PIF_REG_RST 8'h00
`endif

/* hw/pif_flag_reg.v */
// Eight sticky flags, hardware set, software clear by write of zero.
// Assumes set pulses synchronous to clk_i.
`include "pif_defs.vh"
module pif_flag_reg
#(
    parameter [7:0] MASK = 8'hFF
)
(
    input wire clk_i,
    input wire srst_i,
    input wire [7:0] set_i,
    input wire wr_i,
    input wire [7:0] wdata_i,
    output wire [7:0] flags_o
);
    reg [7:0] flags_q;
    reg [7:0] flags_d;

    always @*
    begin
        flags_d = flags_q;
        if (wr_i)
        begin
            flags_d = wdata_i & MASK;
        end
        // Set wins over a clear in the same cycle
        flags_d = (flags_d | set_i) & MASK;
    end

    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            flags_q <= `PIF_REG_RST;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;
endmodule

/* hw/pif_en_reg.v */
// One masked read-write enable bank.
// Assumes write strobe already decoded.
`include "pif_defs.vh"
module pif_en_reg
#(
    parameter [7:0] MASK = 8'hFF
)
(
    input wire clk_i,
    input wire srst_i,
    input wire wr_i,
    input wire [7:0] wdata_i,
    output wire [7:0] en_o
);
    reg [7:0] en_q;

    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            en_q <= `PIF_REG_RST;
        end
        else if (wr_i)
        begin
            en_q <= wdata_i & MASK;
        end
    end

    assign en_o = en_q;
endmodule

/* hw/pif_top.v */
// Peripheral interrupt enable and flag banks with one core request.
// Assumes a classic Wishbone master and event pulses on clk_i.
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`include "pif_defs.vh"
module pif_top
(
    input wire clk_i,
    input wire srst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire [7:0] flag0_set_i,
    input wire pin_change_flag_i,
    input wire [7:0] flag1_set_i,
    input wire [7:0] flag2_set_i,
    input wire [7:0] flag3_set_i,
    input wire serial_a_rx_nempty_i,
    input wire serial_a_tx_nfull_i,
    input wire serial_b_rx_nempty_i,
    input wire serial_b_tx_nfull_i,
    output wire ext_edge_rising_o,
    output wire irq_o
);
    reg ack_q;
    reg [31:0] dat_q;
    reg [31:0] dat_d;
    reg [7:0] ctrl_q;
    wire req;
    wire wr;
    wire [7:0] wb8;
    wire [8:0] en_wr;
    wire [3:0] fl_wr;
    wire [7:0] en0;
    wire [7:0] en1;
    wire [7:0] en2;
    wire [7:0] en3;
    wire [7:0] en4;
    wire [7:0] en5;
    wire [7:0] en6;
    wire [7:0] en7;
    wire [7:0] fl0_q;
    wire [7:0] fl1;
    wire [7:0] fl2;
    wire [7:0] fl3_q;
    wire [7:0] fl0;
    wire [7:0] fl3;
    wire bank0_hit;
    wire periph_hit;
    reg irq_q;

    // Request taken once; ack drops the cycle after it rises
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign wb8 = wb_dat_i[7:0];

    assign en_wr[0] = wr & (wb_adr_i == `PIF_ADR_EN0);
    assign en_wr[1] = wr & (wb_adr_i == `PIF_ADR_EN1);
    assign en_wr[2] = wr & (wb_adr_i == `PIF_ADR_EN2);
    assign en_wr[3] = wr & (wb_adr_i == `PIF_ADR_EN3);
    assign en_wr[4] = wr & (wb_adr_i == `PIF_ADR_EN4);
    assign en_wr[5] = wr & (wb_adr_i == `PIF_ADR_EN5);
    assign en_wr[6] = wr & (wb_adr_i == `PIF_ADR_EN6);
    assign en_wr[7] = wr & (wb_adr_i == `PIF_ADR_EN7);
    assign en_wr[8] = wr & (wb_adr_i == `PIF_ADR_CTRL);
    assign fl_wr[0] = wr & (wb_adr_i == `PIF_ADR_FL0);
    assign fl_wr[1] = wr & (wb_adr_i == `PIF_ADR_FL1);
    assign fl_wr[2] = wr & (wb_adr_i == `PIF_ADR_FL2);
    assign fl_wr[3] = wr & (wb_adr_i == `PIF_ADR_FL3);

    pif_en_reg #(.MASK(`PIF_EN0_MASK)) u_en0 (.clk_i(clk_i),
        .srst_i(srst_i), .wr_i(en_wr[0]), .wdata_i(wb8), .en_o(en0));
    pif_en_reg #(.MASK(`PIF_EN1_MASK)) u_en1 (.clk_i(clk_i),
        .srst_i(srst_i), .wr_i(en_wr[1]), .wdata_i(wb8), .en_o(en1));
    pif_en_reg #(.MASK(`PIF_EN2_MASK)) u_en2 (.clk_i(clk_i),
        .srst_i(srst_i), .wr_i(en_wr[2]), .wdata_i(wb8), .en_o(en2));
    pif_en_reg #(.MASK(`PIF_EN3_MASK)) u_en3 (.clk_i(clk_i),
        .srst_i(srst_i), .wr_i(en_wr[3]), .wdata_i(wb8), .en_o(en3));
    pif_en_reg #(.MASK(`PIF_EN4_MASK)) u_en4 (.clk_i(clk_i),
        .srst_i(srst_i), .wr_i(en_wr[4]), .wdata_i(wb8), .en_o(en4));
    pif_en_reg #(.MASK(`PIF_EN5_MASK)) u_en5 (.clk_i(clk_i),
        .srst_i(srst_i), .wr_i(en_wr[5]), .wdata_i(wb8), .en_o(en5));
    pif_en_reg #(.MASK(`PIF_EN6_MASK)) u_en6 (.clk_i(clk_i),
        .srst_i(srst_i), .wr_i(en_wr[6]), .wdata_i(wb8), .en_o(en6));
    pif_en_reg #(.MASK(`PIF_EN7_MASK)) u_en7 (.clk_i(clk_i),
        .srst_i(srst_i), .wr_i(en_wr[7]), .wdata_i(wb8), .en_o(en7));

    // Timer zero overflow and external pin flags
    pif_flag_reg #(.MASK(`PIF_FL0_MASK)) u_fl0 (.clk_i(clk_i),
        .srst_i(srst_i), .set_i(flag0_set_i), .wr_i(fl_wr[0]),
        .wdata_i(wb8), .flags_o(fl0_q));
    pif_flag_reg #(.MASK(`PIF_FL1_MASK)) u_fl1 (.clk_i(clk_i),
        .srst_i(srst_i), .set_i(flag1_set_i), .wr_i(fl_wr[1]),
        .wdata_i(wb8), .flags_o(fl1));
    // Zero cross and comparator flags
    pif_flag_reg #(.MASK(`PIF_FL2_MASK)) u_fl2 (.clk_i(clk_i),
        .srst_i(srst_i), .set_i(flag2_set_i), .wr_i(fl_wr[2]),
        .wdata_i(wb8), .flags_o(fl2));
    // Sync port flags only; serial bits are live status
    pif_flag_reg #(.MASK(`PIF_FL3_MASK)) u_fl3 (.clk_i(clk_i),
        .srst_i(srst_i), .set_i(flag3_set_i), .wr_i(fl_wr[3]),
        .wdata_i(wb8), .flags_o(fl3_q));

    // Pin change summary is read-only, cleared at its source
    assign fl0 = fl0_q | ({7'h00, pin_change_flag_i} << `PIF_FL0_PINCHG_BIT);
    assign fl3 = fl3_q
        | ({7'h00, serial_b_rx_nempty_i} << `PIF_FL3_RXB_BIT)
        | ({7'h00, serial_a_rx_nempty_i} << `PIF_FL3_RXA_BIT)
        | ({7'h00, serial_b_tx_nfull_i} << `PIF_FL3_TXB_BIT)
        | ({7'h00, serial_a_tx_nfull_i} << `PIF_FL3_TXA_BIT);

    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            ctrl_q <= `PIF_CTRL_RST;
        end
        else if (en_wr[8])
        begin
            ctrl_q <= wb8 & `PIF_CTRL_MASK;
        end
    end

    // Banks four to seven have no flags here; their enables are storage
    assign bank0_hit = |(fl0 & en0);
    assign periph_hit = |(fl1 & en1) | |(fl2 & en2) | |(fl3 & en3);

    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= ctrl_q[`PIF_CTRL_GIE_BIT] & (bank0_hit
                | (ctrl_q[`PIF_CTRL_PERIPHERAL_IRQ_MASTER_ENABLE_BIT] & periph_hit));
        end
    end

    assign irq_o = irq_q;
    assign ext_edge_rising_o = ctrl_q[`PIF_CTRL_EDGE_BIT];

    always @*
    begin
        dat_d = 32'h00000000;
        case (wb_adr_i)
            `PIF_ADR_CTRL: dat_d[7:0] = ctrl_q;
            `PIF_ADR_EN0: dat_d[7:0] = en0;
            `PIF_ADR_EN1: dat_d[7:0] = en1;
            `PIF_ADR_EN2: dat_d[7:0] = en2;
            `PIF_ADR_EN3: dat_d[7:0] = en3;
            `PIF_ADR_EN4: dat_d[7:0] = en4;
            `PIF_ADR_EN5: dat_d[7:0] = en5;
            `PIF_ADR_EN6: dat_d[7:0] = en6;
            `PIF_ADR_EN7: dat_d[7:0] = en7;
            `PIF_ADR_FL0: dat_d[7:0] = fl0;
            `PIF_ADR_FL1: dat_d[7:0] = fl1;
            `PIF_ADR_FL2: dat_d[7:0] = fl2;
            `PIF_ADR_FL3: dat_d[7:0] = fl3;
            default: dat_d = 32'h00000000;
        endcase
    end

    // Unmapped addresses ack with zero so the bus never hangs
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= req;
            dat_q <= req ? dat_d : 32'h00000000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule

/* tb/pif_assertions.sv */
// Port checker for the interrupt flag block.
// Bound to pif_top; sees only its ports.
module pif_chk
(
    input wire clk_i,
    input wire srst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire serial_a_rx_nempty_i,
    input wire serial_a_tx_nfull_i,
    input wire serial_b_rx_nempty_i,
    input wire serial_b_tx_nfull_i,
    input wire ext_edge_rising_o,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wt = req & wb_we_i;
    wire [3:0] lv = {serial_b_rx_nempty_i, serial_b_tx_nfull_i,
        serial_a_rx_nempty_i, serial_a_tx_nfull_i};
    // Taking edge of a bank three read; ack and data follow one edge later
    wire rd3 = req & ~wb_we_i & (wb_adr_i == 6'h30);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_ack_next: assert property (req |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data while idle");
    a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper data set");
    a_rx_level: assert property ($past(rd3) |-> ##0 wb_ack_o ##0
        {wb_dat_o[7], wb_dat_o[5]} == {$past(lv[3]), $past(lv[1])})
        else $error("rx flag wrong");
    a_tx_level: assert property ($past(rd3) |-> ##0 wb_ack_o ##0
        {wb_dat_o[6], wb_dat_o[4]} == {$past(lv[2]), $past(lv[0])})
        else $error("tx flag wrong");
    a_irq_fall: assert property ($fell(irq_o) |-> $past(wt, 2) ||
        $past(lv) != $past(lv, 2) || $past(lv, 2) != $past(lv, 3))
        else $error("irq fell alone");
    a_edge_reset: assert property ($past(srst_i) |-> ext_edge_rising_o)
        else $error("edge select reset");
endmodule

bind pif_top pif_chk i_chk (.clk_i(clk_i), .srst_i(srst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_a_rx_nempty_i(serial_a_rx_nempty_i),
    .serial_a_tx_nfull_i(serial_a_tx_nfull_i),
    .serial_b_rx_nempty_i(serial_b_rx_nempty_i),
    .serial_b_tx_nfull_i(serial_b_tx_nfull_i),
    .ext_edge_rising_o(ext_edge_rising_o), .irq_o(irq_o));

/* tb/pif_src_model.sv */
// Event sources and serial buffer levels facing the flag block.
// Commanded by the bench; changes just after clk_i edges.
module pif_src_model
(
    input wire clk_i,
    output logic [31:0] set_o,
    output logic [4:0] lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial set_o = 32'h0;
    initial lvl_o = 5'h05;
    // One-cycle event, raised whatever the enables say
    task automatic pulse(input int b, input logic [7:0] v);
        @(posedge clk_i);
        set_o[b*8+:8] <= v;
        @(posedge clk_i);
        set_o <= 32'h0;
    endtask
    // Buffer levels: pin, rx b, tx b, rx a, tx a
    task automatic lvl(input logic [4:0] v);
        @(posedge clk_i);
        lvl_o <= v;
    endtask
endmodule

/* tb/pif_top_tb_top.sv */
// Bench for the interrupt flag block over classic Wishbone.
// Uses pif_src_model for events and buffer levels.
module pif_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, srst_i, cyc, we, ack, edg, irq;
    logic [5:0] adr;
    logic [31:0] dat, rdat, set;
    logic [4:0] lv;
    logic [7:0] q;
    int fails, total_checks;
    logic [7:0] rv [13] = '{0:8'h01, 12:8'h50, default:8'h00};
    logic [7:0] em [8] = '{8'h31, 8'hC1, 8'h43, 8'hF3, 8'h03, 8'hF1,
        8'h03, 8'h31};
    pif_src_model i_src (.clk_i(clk_i), .set_o(set), .lvl_o(lv));
    pif_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .flag0_set_i(set[7:0]), .pin_change_flag_i(lv[4]),
        .flag1_set_i(set[15:8]), .flag2_set_i(set[23:16]),
        .flag3_set_i(set[31:24]), .serial_a_rx_nempty_i(lv[1]),
        .serial_a_tx_nfull_i(lv[0]), .serial_b_rx_nempty_i(lv[3]),
        .serial_b_tx_nfull_i(lv[2]), .ext_edge_rising_o(edg),
        .irq_o(irq));
    task automatic chk(input string n, input logic [7:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask
    // Holds the request until ack is sampled high
    task automatic wb(input logic w, input logic [5:0] a,
        input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        q = rdat[7:0];
        cyc <= 1'b0;
    endtask
    task automatic rc(input logic [5:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), e, q);
    endtask
    // Flags land at one edge, the request at the next
    task automatic ic(input logic e);
        repeat (2) @(posedge clk_i);
        chk("irq", {7'h0, e}, {7'h0, irq});
    endtask
    task automatic end_sim;
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        end_sim();
    end
    initial
    begin
        srst_i = 1'b1;
        {cyc, we, adr, dat, fails, total_checks} = '0;
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 13; i++)
            rc(i * 4, rv[i]);
        rc(6'h34, 8'h00);
        for (int i = 1; i < 9; i++)
        begin
            wb(1'b1, i * 4, 8'hFF);
            rc(i * 4, em[i - 1]);
            wb(1'b1, i * 4, 8'h00);
        end
        wb(1'b1, 6'h34, 8'hFF);
        rc(6'h34, 8'h00);
        for (int b = 0; b < 4; b++)
            i_src.pulse(b, 8'hFF);
        rc(6'h24, 8'h21);
        rc(6'h2C, 8'h43);
        rc(6'h28, 8'hC1);
        wb(1'b1, 6'h0C, 8'h43);
        // Peripheral master on, global off: nothing may pass
        wb(1'b1, 6'h00, 8'h41);
        ic(1'b0);
        wb(1'b1, 6'h00, 8'hC1);
        ic(1'b1);
        wb(1'b1, 6'h00, 8'h81);
        ic(1'b0);
        wb(1'b1, 6'h24, 8'h00);
        wb(1'b1, 6'h04, 8'h20);
        ic(1'b0);
        i_src.pulse(0, 8'h20);
        ic(1'b1);
        repeat (20) @(posedge clk_i);
        rc(6'h24, 8'h20);
        wb(1'b1, 6'h24, 8'h00);
        ic(1'b0);
        i_src.lvl(5'h1A);
        rc(6'h30, 8'hA3);
        rc(6'h24, 8'h10);
        wb(1'b1, 6'h30, 8'h00);
        rc(6'h30, 8'hA0);
        wb(1'b1, 6'h10, 8'hF0);
        // Stale bank two flags would mask the serial checks below
        wb(1'b1, 6'h2C, 8'h00);
        rc(6'h2C, 8'h00);
        wb(1'b1, 6'h00, 8'hC0);
        chk("edge", 8'h00, {7'h0, edg});
        ic(1'b1);
        i_src.lvl(5'h00);
        ic(1'b0);
        i_src.lvl(5'h05);
        ic(1'b1);
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        rc(6'h0C, 8'h00);
        ic(1'b0);
        end_sim();
    end
endmodule
